//--- cpu_iface_map.vh
/*
  Register map constants for the CPU-interface control and FIFO status slice.
  Assumes a 32-bit Avalon-MM slave with byte addresses.
*/
`ifndef CPU_IFACE_MAP_VH
`define CPU_IFACE_MAP_VH

`define ADDR_W 12
`define CPU_CONTROL_OFS 12'h000
`define FIFO_STATUS_OFS 12'h004
`define CTRL_RESET 8'h00
`define TSEL_LSB 4
`define TSEL_MSB 5
`define TDATA_LSB 6
`define TDATA_MSB 7
`define CTRL_LSB 0
`define CTRL_MSB 7
`define CTRL_LANE 0
`define CFREE_LSB 0
`define CFREE_MSB 4
`define SFREE_LSB 8
`define SFREE_MSB 12
`define BUSY_BIT 16
`define FIFO_DEPTH 16
`define COUNT_W 5
`define PAIR_W 2
`define TSEL_USB 2'h0
`define TSEL_MIU 2'h1
`define TSEL_CIF 2'h2
`define GPIO_W 14
`define GPIO_ZERO 14'h0000
`define WORD_ZERO 32'h0000_0000

`endif

//--- cpu_iface_fifo_status_regs.v
/*
  CPU control register (test source fields) and FIFO/engine status register.
  Assumes free counts and busy come synchronous to clk_in from the FIFOs and engine.
*/
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ps
`include "cpu_iface_map.vh"

module cpu_iface_fifo_status_regs
#(
  parameter FIFO_DEPTH = `FIFO_DEPTH,
  parameter COUNT_W = `COUNT_W
)
(
  // Clock and reset
  input wire clk_in,
  input wire resetn_in,
  // Avalon-MM slave
  input wire [`ADDR_W-1:0] address_in,
  input wire read_in,
  input wire write_in,
  input wire [31:0] writedata_in,
  input wire [3:0] byteenable_in,
  output reg [31:0] readdata_out,
  output reg waitrequest_out,
  // FIFO and engine state
  input wire [COUNT_W-1:0] cmd_fifo_free_count_in,
  input wire [COUNT_W-1:0] src_fifo_free_count_in,
  input wire engine_busy_in,
  // Test data from other units
  input wire [`GPIO_W-1:0] usb_test_data_in,
  input wire [`GPIO_W-1:0] miu_test_data_in,
  input wire [`GPIO_W-1:0] cif_test_data_in,
  // Test outputs
  output reg [`GPIO_W-1:0] test_gpio_data_out,
  output reg [1:0] test_source_sel_out
);

  // Handshake states
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_ANSWER = 2'h2;
  localparam [COUNT_W-1:0] FREE_LIMIT = FIFO_DEPTH[COUNT_W-1:0];

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [`CTRL_MSB:0] ctrl_q;
  reg [`CTRL_MSB:0] ctrl_d;
  reg waitrequest_d;
  reg [31:0] readdata_d;
  reg [31:0] status_d;
  reg [31:0] rdata_d;
  reg [`GPIO_W-1:0] gpio_d;
  wire req_w;
  wire idle_w;
  wire take_w;
  wire ctrl_hit_w;
  wire status_hit_w;
  wire ctrl_wr_w;
  wire [1:0] tsel_w;
  wire [1:0] tdata_w;
  wire [`GPIO_W-1:0] cif_data_w;

  // Exact match of a register offset
  function addr_hit;
    input [`ADDR_W-1:0] addr;
    input [`ADDR_W-1:0] ofs;
    begin
      addr_hit = (addr == ofs);
    end
  endfunction

  // Clamp counts above depth to depth
  function [COUNT_W-1:0] clamp_free;
    input [COUNT_W-1:0] cnt;
    begin
      clamp_free = (cnt > FREE_LIMIT) ? FREE_LIMIT : cnt;
    end
  endfunction

  assign req_w = read_in | write_in;
  assign idle_w = (state_q == ST_IDLE);
  assign take_w = req_w & idle_w;
  assign ctrl_hit_w = addr_hit(address_in, `CPU_CONTROL_OFS);
  assign status_hit_w = addr_hit(address_in, `FIFO_STATUS_OFS);
  assign ctrl_wr_w = take_w & write_in & ctrl_hit_w & byteenable_in[`CTRL_LANE];
  assign tsel_w = ctrl_q[`TSEL_MSB:`TSEL_LSB];
  assign tdata_w = ctrl_q[`TDATA_MSB:`TDATA_LSB];

  // CPU interface data replicated in every bit pair
  genvar pair_g;
  generate
    for (pair_g = 0; pair_g < `GPIO_W / `PAIR_W; pair_g = pair_g + 1)
    begin : gen_pair
      assign cif_data_w[pair_g * `PAIR_W +: `PAIR_W] = tdata_w;
    end
  endgenerate

  always @*
  begin
    status_d = `WORD_ZERO;
    status_d[`CFREE_MSB:`CFREE_LSB] = clamp_free(cmd_fifo_free_count_in);
    status_d[`SFREE_MSB:`SFREE_LSB] = clamp_free(src_fifo_free_count_in);
    status_d[`BUSY_BIT] = engine_busy_in;
  end

  always @*
  begin
    rdata_d = `WORD_ZERO;
    if (ctrl_hit_w)
    begin
      rdata_d[`CTRL_MSB:`CTRL_LSB] = ctrl_q;
    end
    else if (status_hit_w)
    begin
      rdata_d = status_d;
    end
  end

  // One wait cycle per access: answer on the second edge
  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (req_w)
        begin
          state_d = ST_ANSWER;
        end
      end
      ST_ANSWER:
      begin
        state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @*
  begin
    ctrl_d = ctrl_q;
    if (ctrl_wr_w)
    begin
      ctrl_d[`TDATA_MSB:`TSEL_LSB] = writedata_in[`TDATA_MSB:`TSEL_LSB];
    end
  end

  // Read data held until the next access
  always @*
  begin
    waitrequest_d = (state_d != ST_ANSWER);
    readdata_d = readdata_out;
    if (take_w)
    begin
      if (read_in)
      begin
        readdata_d = rdata_d;
      end
      else
      begin
        readdata_d = `WORD_ZERO;
      end
    end
  end

  // Test data source select
  always @*
  begin
    case (tsel_w)
      `TSEL_USB:
      begin
        gpio_d = usb_test_data_in;
      end
      `TSEL_MIU:
      begin
        gpio_d = miu_test_data_in;
      end
      `TSEL_CIF:
      begin
        gpio_d = cif_test_data_in | cif_data_w;
      end
      default:
      begin
        gpio_d = `GPIO_ZERO;
      end
    endcase
  end

  always @(posedge clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      state_q <= ST_IDLE;
      ctrl_q <= `CTRL_RESET;
      waitrequest_out <= 1'h1;
      readdata_out <= `WORD_ZERO;
      test_gpio_data_out <= `GPIO_ZERO;
      test_source_sel_out <= `TSEL_USB;
    end
    else
    begin
      state_q <= state_d;
      ctrl_q <= ctrl_d;
      waitrequest_out <= waitrequest_d;
      readdata_out <= readdata_d;
      test_source_sel_out <= tsel_w;
      test_gpio_data_out <= gpio_d;
    end
  end

endmodule

//--- regs_chk_asserts.sv
/* Port checker for the control and status register slice.
   Assumes it is bound into the register block and sees only its ports. */
`timescale 1ns/1ps
module regs_chk(input wire clk_in, resetn_in, read_in, waitrequest_out, input wire [11:0] address_in,
  input wire [31:0] readdata_out, input wire [1:0] test_source_sel_out, input wire [13:0] test_gpio_data_out);
  wire s = read_in && waitrequest_out && address_in == 12'h004;
  wire [31:0] r = readdata_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  a_top_zero: assert property (!r[31:17]) else $error("top");
  a_gap_zero: assert property (s |=> !r[15:13] && !r[7:5]) else $error("gap");
  a_cmd_max: assert property (s |=> r[4:0] < 5'h11) else $error("cmd");
  a_src_max: assert property (s |=> r[12:8] < 5'h11) else $error("src");
  a_ctrl_zero: assert property (read_in && !address_in |=> !r[31:8] && !r[3:0]) else $error("ctl");
  a_sel_read: assert property (read_in && !waitrequest_out && !address_in |-> r[5:4] == test_source_sel_out)
    else $error("sel");
  a_code_rsvd: assert property (&test_source_sel_out |-> !test_gpio_data_out) else $error("rsv");
  a_wait_one: assert property (!waitrequest_out |=> waitrequest_out) else $error("wait");
endmodule
bind cpu_iface_fifo_status_regs regs_chk regs_chk_i(.clk_in(clk_in), .resetn_in(resetn_in), .read_in(read_in),
  .waitrequest_out(waitrequest_out), .address_in(address_in), .readdata_out(readdata_out),
  .test_source_sel_out(test_source_sel_out), .test_gpio_data_out(test_gpio_data_out));

//--- host.sv
/* Host bus master.
   Needs the bench clock. */
`timescale 1ns/1ps
module host(input wire clk_in, wait_in, input wire [31:0] rdata_in,
  output reg [11:0] addr_out = 0, output reg rd_out = 0, wr_out = 0, output reg [31:0] wd_out = 0);
  task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] q);
    begin
      @(posedge clk_in) {addr_out, wd_out, wr_out, rd_out} <= {a, d, w, !w};
      @(posedge clk_in) while (wait_in) @(posedge clk_in);
      q = rdata_in;
      {wr_out, rd_out} <= 2'h0;
    end
  endtask
endmodule

//--- cpu_iface_fifo_status_regs_tb.sv
/* Bench.
   Needs host. */
`timescale 1ns/1ps
module cpu_iface_fifo_status_regs_tb;
  reg clk_in = 0, resetn_in = 0, engine_busy_in = 0;
  reg [4:0] cmd_fifo_free_count_in = 0, src_fifo_free_count_in = 0;
  reg [13:0] usb_test_data_in = 14'h1234, miu_test_data_in = 14'h0abc, cif_test_data_in = 14'h0001;
  wire [31:0] writedata_in, readdata_out;
  wire [11:0] address_in;
  wire [13:0] test_gpio_data_out;
  wire [3:0] byteenable_in = 4'hf;
  wire [1:0] test_source_sel_out;
  wire read_in, write_in, waitrequest_out;
  integer errors = 0, checks = 0, cyc = 0, i;
  reg [31:0] q;
  always #5 clk_in = !clk_in;
  cpu_iface_fifo_status_regs cpu_iface_fifo_status_regs_i(.clk_in, .resetn_in, .address_in, .read_in,
    .write_in, .writedata_in, .byteenable_in, .readdata_out, .waitrequest_out,
    .cmd_fifo_free_count_in, .src_fifo_free_count_in, .engine_busy_in, .usb_test_data_in,
    .miu_test_data_in, .cif_test_data_in, .test_gpio_data_out, .test_source_sel_out);
  host host_i(.clk_in, .wait_in(waitrequest_out), .rdata_in(readdata_out), .addr_out(address_in),
    .rd_out(read_in), .wr_out(write_in), .wd_out(writedata_in));
  task chk(input [31:0] g, e);
    begin checks++; if (g !== e) begin errors++; $display("Error %0t got %h exp %h", $time, g, e); end end
  endtask
  task print_verdict;
    begin
      $display("errors %0d checks %0d", errors, checks);
      if (!errors && checks) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
    end
  endtask
  task scan;
    begin
      for (i = 0; i < 17; i++) begin
        @(posedge clk_in) {cmd_fifo_free_count_in, src_fifo_free_count_in, engine_busy_in} <= {i[4:0], 5'h10 - i[4:0], i[0]};
        host_i.xfer(0, 12'h004, 0, q);
        chk(q, {15'h0, i[0], 3'h0, 5'h10 - i[4:0], 3'h0, i[4:0]});
      end
      @(posedge clk_in) {cmd_fifo_free_count_in, src_fifo_free_count_in, engine_busy_in} <= {5'h1f, 5'h11, 1'h1};
      host_i.xfer(0, 12'h004, 0, q);
      chk(q, 32'h0001_1010);
    end
  endtask
  task codes;
    begin
      host_i.xfer(0, 12'h000, 0, q);
      chk(q, 0);
      for (i = 0; i < 4; i++) begin
        host_i.xfer(1, 12'h000, {24'hff_ffff, 2'h2, i[1:0], 4'hf}, q);
        host_i.xfer(0, 12'h000, 0, q);
        chk(q, {2'h2, i[1:0], 4'h0});
        chk(test_gpio_data_out, i == 0 ? 14'h1234 : i == 1 ? 14'h0abc : i == 2 ? 14'h2aab : 14'h0);
        chk(test_source_sel_out, i);
      end
      host_i.xfer(1, 12'h004, 32'hffff_ffff, q);
      host_i.xfer(1, 12'h008, 32'hffff_ffff, q);
      host_i.xfer(0, 12'h000, 0, q);
      chk(q, 32'h0000_00b0);
    end
  endtask
  always @(posedge clk_in) if (++cyc == 900) begin errors++; print_verdict; end
  initial begin
    repeat (20) @(posedge clk_in);
    resetn_in <= 1;
    scan;
    codes;
    host_i.xfer(0, 12'h008, 0, q);
    chk(q, 0);
    print_verdict;
  end
endmodule
